// ---- hdl/gst_pkg.sv ----
// Notes on behaviour
// - An external input only triggers when software enables it in the OR mask or the AND mask.
// - The main input is enabled by mask value 2 and the secondary input by mask value 4h.
// - One-level modes work on both inputs, while two-level modes work on the main input only.
// - Every valid sample of the digitized trigger input taken while running is compared against the levels.
// - Rising-edge mode opens the gate on an upward crossing and closes it on the next downward one.
// - Edge modes need a real crossing, so a signal already past the level at start does nothing.
// - Falling-edge mode opens the gate on a downward crossing and closes it on the next upward one.
// - In re-arm mode a re-arm level crossing arms the engine, and an opening trigger disarms it.
// - Positive re-arm mode closes the gate on a downward trigger crossing, with the re-arm level in the second level register.
// - The recorded gate length is padded up to the next alignment boundary.
// - Gate timestamps mark the true gate edges, not the padded end.
// - With timestamps on, each segment gives one timestamp at opening and one at closing.
// - A segment starts at start minus pretrigger and spans end minus start plus pad, pretrigger and posttrigger.
// - When the memory-size counter expires the recording ends, with an extra timestamp for an open gate.
package gst_pkg;
	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_OR_MASK     = 16'h9dda;
	localparam logic [15:0] IDX_AND_MASK    = 16'h9dee;
	localparam logic [15:0] IDX_MODE_MAIN   = 16'h9e3e;
	localparam logic [15:0] IDX_MODE_SEC    = 16'h9e3f;
	localparam logic [15:0] IDX_LVL_FIRST   = 16'ha550;
	localparam logic [15:0] IDX_LVL_SECOND  = 16'ha55a;
	localparam logic [15:0] IDX_CTRL        = 16'ha600;
	localparam logic [15:0] IDX_SEC_LVL     = 16'ha601;
	localparam logic [15:0] IDX_ALIGN       = 16'ha602;
	localparam logic [15:0] IDX_PRE         = 16'ha603;
	localparam logic [15:0] IDX_POST        = 16'ha604;
	localparam logic [15:0] IDX_MEMSIZE     = 16'ha605;
	localparam logic [15:0] IDX_STATUS      = 16'ha606;
	localparam logic [15:0] IDX_TS_START    = 16'ha607;
	localparam logic [15:0] IDX_TS_END      = 16'ha608;
	localparam logic [15:0] IDX_SEG_FIRST   = 16'ha609;
	localparam logic [15:0] IDX_SEG_LEN     = 16'ha60a;
	localparam int          APB_AW          = 18;
	// Mask and mode encodings
	localparam logic [31:0] MAIN_EXT_SOURCE_BIT      = 32'h0000_0002;
	localparam logic [31:0] SECONDARY_EXT_SOURCE_BIT = 32'h0000_0004;
	localparam logic [31:0] RISING_EDGE_MODE         = 32'h0000_0001;
	localparam logic [31:0] FALLING_EDGE_MODE        = 32'h0000_0002;
	localparam logic [31:0] REARM_QUALIFIER          = 32'h0100_0000;
	// Control fields
	localparam int          CTRL_RUN_BIT   = 0;
	localparam int          CTRL_TS_BIT    = 1;
	// Reset values
	localparam logic [31:0] RST_ZERO       = 32'h0000_0000;
	localparam logic [31:0] RST_ALIGN      = 32'h0000_0020;
	localparam logic [31:0] RST_MEMSIZE    = 32'h0000_1000;
	// Segment sequencer states
	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_WAIT  = 3'b001,
		S_GATE  = 3'b010,
		S_ALIGN = 3'b011,
		S_POST  = 3'b100,
		S_DONE  = 3'b101
	} gst_seg_state_type;
endpackage

// ---- hdl/gst_xing.sv ----
`timescale 1ns/1ps
`default_nettype none
// Level crossing detector between two consecutive samples
module gst_xing #(
	parameter int W = 32
) (
	input  wire logic                i_valid,
	input  wire logic signed [W-1:0] i_prev,
	input  wire logic signed [W-1:0] i_cur,
	input  wire logic signed [W-1:0] i_level,
	output logic                     o_up,
	output logic                     o_down
);
	// Landing exactly on the level counts as crossed
	assign o_up   = i_valid && (i_prev < i_level) && (i_cur >= i_level);
	assign o_down = i_valid && (i_prev > i_level) && (i_cur <= i_level);
endmodule // gst_xing
`default_nettype wire

// ---- hdl/gst_gate_trigger.sv ----
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module gst_gate_trigger #(
	parameter int SMP_W = 16
) (
	input  wire logic                       i_clk_sys,
	input  wire logic                       i_rst_n,
	input  wire logic                       i_psel,
	input  wire logic                       i_penable,
	input  wire logic                       i_pwrite,
	input  wire logic [gst_pkg::APB_AW-1:0] i_paddr,
	input  wire logic [31:0]                i_pwdata,
	output logic      [31:0]                o_prdata,
	output logic                            o_pready,
	output logic                            o_pslverr,
	input  wire logic                       i_sample_valid,
	input  wire logic [SMP_W-1:0]           i_main_ext_sample,
	input  wire logic [SMP_W-1:0]           i_sec_ext_sample,
	output logic                            o_gate,
	output logic                            o_record,
	output logic                            o_done,
	output logic                            o_ts_strobe,
	output logic                            o_ts_is_end,
	output logic      [31:0]                o_ts_value,
	output logic                            o_seg_strobe,
	output logic      [31:0]                o_seg_first,
	output logic      [31:0]                o_seg_len
);
	logic [31:0] or_mask, and_mask, mode_main, mode_sec;
	logic [31:0] lvl_first, lvl_second, sec_lvl, ctrl;
	logic [31:0] align, pre, post, memsize;
	logic [31:0] ts_start, ts_end, pad_q, cnt, mem_left, sample_cnt;
	logic [31:0] rd_data, next_pad;
	logic        rd_hit, run, ts_en, sv, xv, have_prev;
	logic signed [31:0] cur_main, cur_sec, prev_main, prev_sec;
	logic        up_a, down_a, up_b, down_b, up_s, down_s;
	logic        main_gate, main_armed, sec_gate;
	logic        next_main_gate, next_main_armed, next_sec_gate;
	logic        main_open, main_close, main_arm;
	logic        main_pos, main_neg, main_rearm, sec_pos, sec_neg, sec_rearm;
	logic [1:0]  next_src, or_sel, and_sel;
	logic        gate_comb, gate_rise, mem_last;
	logic [15:0] idx;
	gst_pkg::gst_seg_state_type state;

	assign run      = ctrl[gst_pkg::CTRL_RUN_BIT];
	assign ts_en    = ctrl[gst_pkg::CTRL_TS_BIT];
	assign idx      = i_paddr[gst_pkg::APB_AW-1:2];
	assign cur_main = 32'(signed'(i_main_ext_sample));
	assign cur_sec  = 32'(signed'(i_sec_ext_sample));
	// Every valid sample while running is evaluated
	assign sv       = run && i_sample_valid;
	assign xv       = sv && have_prev;

	// Read decode; RO words show live engine state
	always_comb begin
		rd_data = gst_pkg::RST_ZERO;
		rd_hit  = (i_paddr[1:0] == 2'h0);
		if (idx == gst_pkg::IDX_OR_MASK) begin
			rd_data = or_mask;
		end else if (idx == gst_pkg::IDX_AND_MASK) begin
			rd_data = and_mask;
		end else if (idx == gst_pkg::IDX_MODE_MAIN) begin
			rd_data = mode_main;
		end else if (idx == gst_pkg::IDX_MODE_SEC) begin
			rd_data = mode_sec;
		end else if (idx == gst_pkg::IDX_LVL_FIRST) begin
			rd_data = lvl_first;
		end else if (idx == gst_pkg::IDX_LVL_SECOND) begin
			rd_data = lvl_second;
		end else if (idx == gst_pkg::IDX_CTRL) begin
			rd_data = ctrl;
		end else if (idx == gst_pkg::IDX_SEC_LVL) begin
			rd_data = sec_lvl;
		end else if (idx == gst_pkg::IDX_ALIGN) begin
			rd_data = align;
		end else if (idx == gst_pkg::IDX_PRE) begin
			rd_data = pre;
		end else if (idx == gst_pkg::IDX_POST) begin
			rd_data = post;
		end else if (idx == gst_pkg::IDX_MEMSIZE) begin
			rd_data = memsize;
		end else if (idx == gst_pkg::IDX_STATUS) begin
			rd_data = {24'h00_0000, main_armed, sec_gate, main_gate, o_gate, state, o_done};
		end else if (idx == gst_pkg::IDX_TS_START) begin
			rd_data = ts_start;
		end else if (idx == gst_pkg::IDX_TS_END) begin
			rd_data = ts_end;
		end else if (idx == gst_pkg::IDX_SEG_FIRST) begin
			rd_data = o_seg_first;
		end else if (idx == gst_pkg::IDX_SEG_LEN) begin
			rd_data = o_seg_len;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// APB answer: no wait state; read data is taken into a flop in the setup cycle
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_pready  <= 1'b0;
			o_prdata  <= gst_pkg::RST_ZERO;
			o_pslverr <= 1'b0;
		end else begin
			o_pready  <= i_psel && !i_penable;
			o_pslverr <= i_psel && !i_penable && !rd_hit;
			if (i_psel && !i_penable) begin
				o_prdata <= rd_data;
			end
		end
	end

	// Register writes; only at the completing access edge
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			or_mask    <= gst_pkg::RST_ZERO;
			and_mask   <= gst_pkg::RST_ZERO;
			mode_main  <= gst_pkg::RST_ZERO;
			mode_sec   <= gst_pkg::RST_ZERO;
			lvl_first  <= gst_pkg::RST_ZERO;
			lvl_second <= gst_pkg::RST_ZERO;
			sec_lvl    <= gst_pkg::RST_ZERO;
			ctrl       <= gst_pkg::RST_ZERO;
			align      <= gst_pkg::RST_ALIGN;
			pre        <= gst_pkg::RST_ZERO;
			post       <= gst_pkg::RST_ZERO;
			memsize    <= gst_pkg::RST_MEMSIZE;
		end else if (i_psel && i_penable && o_pready && i_pwrite && rd_hit) begin
			if (idx == gst_pkg::IDX_OR_MASK) begin
				or_mask <= i_pwdata;
			end else if (idx == gst_pkg::IDX_AND_MASK) begin
				and_mask <= i_pwdata;
			end else if (idx == gst_pkg::IDX_MODE_MAIN) begin
				mode_main <= i_pwdata;
			end else if (idx == gst_pkg::IDX_MODE_SEC) begin
				mode_sec <= i_pwdata;
			end else if (idx == gst_pkg::IDX_LVL_FIRST) begin
				lvl_first <= i_pwdata;
			end else if (idx == gst_pkg::IDX_LVL_SECOND) begin
				lvl_second <= i_pwdata;
			end else if (idx == gst_pkg::IDX_CTRL) begin
				ctrl <= i_pwdata;
			end else if (idx == gst_pkg::IDX_SEC_LVL) begin
				sec_lvl <= i_pwdata;
			end else if (idx == gst_pkg::IDX_ALIGN) begin
				align <= i_pwdata;
			end else if (idx == gst_pkg::IDX_PRE) begin
				pre <= i_pwdata;
			end else if (idx == gst_pkg::IDX_POST) begin
				post <= i_pwdata;
			end else if (idx == gst_pkg::IDX_MEMSIZE) begin
				memsize <= i_pwdata;
			end
		end
	end

	// Previous sample; cleared while stopped so start never counts as a crossing
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n || !run) begin
			have_prev <= 1'b0;
			prev_main <= 32'sh0;
			prev_sec  <= 32'sh0;
		end else begin
			if (i_sample_valid) begin
				have_prev <= 1'b1;
				prev_main <= cur_main;
				prev_sec  <= cur_sec;
			end
		end
	end

	// Crossing detectors: main first level, main second level, secondary level
	gst_xing #(.W(32)) u_main_first (
		.i_valid(xv), .i_prev(prev_main), .i_cur(cur_main), .i_level(signed'(lvl_first)),
		.o_up(up_a), .o_down(down_a));
	gst_xing #(.W(32)) u_main_second (
		.i_valid(xv), .i_prev(prev_main), .i_cur(cur_main), .i_level(signed'(lvl_second)),
		.o_up(up_b), .o_down(down_b));
	gst_xing #(.W(32)) u_sec (
		.i_valid(xv), .i_prev(prev_sec), .i_cur(cur_sec), .i_level(signed'(sec_lvl)),
		.o_up(up_s), .o_down(down_s));

	// Mode decode; unknown codes close the main source, while the secondary keeps its current gate
	assign main_rearm = (mode_main & gst_pkg::REARM_QUALIFIER) != gst_pkg::RST_ZERO;
	assign main_pos   = (mode_main & ~gst_pkg::REARM_QUALIFIER) == gst_pkg::RISING_EDGE_MODE;
	assign main_neg   = (mode_main & ~gst_pkg::REARM_QUALIFIER) == gst_pkg::FALLING_EDGE_MODE;
	assign sec_rearm  = (mode_sec & gst_pkg::REARM_QUALIFIER) != gst_pkg::RST_ZERO;
	assign sec_pos    = (mode_sec == gst_pkg::RISING_EDGE_MODE);
	assign sec_neg    = (mode_sec == gst_pkg::FALLING_EDGE_MODE);

	// Main input events per mode
	always_comb begin
		main_open  = 1'b0;
		main_close = 1'b0;
		main_arm   = 1'b0;
		if (main_rearm && main_pos) begin
			main_open  = main_armed && up_a;
			main_close = down_a;
			main_arm   = up_b;
		end else if (main_rearm && main_neg) begin
			main_open  = main_armed && down_b;
			main_close = up_b;
			main_arm   = down_a;
		end else if (main_pos) begin
			main_open  = up_a;
			main_close = down_a;
		end else if (main_neg) begin
			main_open  = down_a;
			main_close = up_a;
		end
	end

	// Next source gates; secondary refuses two-level codes
	always_comb begin
		next_main_gate  = main_open ? 1'b1 : (main_close ? 1'b0 : main_gate);
		// Arming wins over disarm when both land on one sample
		next_main_armed = main_arm ? 1'b1 : (main_open ? 1'b0 : main_armed);
		next_sec_gate   = sec_gate;
		if (!sec_rearm && sec_pos) begin
			next_sec_gate = up_s ? 1'b1 : (down_s ? 1'b0 : sec_gate);
		end else if (!sec_rearm && sec_neg) begin
			next_sec_gate = down_s ? 1'b1 : (up_s ? 1'b0 : sec_gate);
		end
		if (!main_pos && !main_neg) begin
			next_main_gate  = 1'b0;
			next_main_armed = 1'b0;
		end
		if (sec_rearm) begin
			next_sec_gate = 1'b0;
		end
	end

	// Mask combination on the next source state, so edges align with their sample
	assign next_src  = {next_sec_gate, next_main_gate};
	assign or_sel    = {or_mask[2], or_mask[1]} & 2'({gst_pkg::SECONDARY_EXT_SOURCE_BIT[2],
		gst_pkg::MAIN_EXT_SOURCE_BIT[1]});
	assign and_sel   = {and_mask[2], and_mask[1]} & 2'({gst_pkg::SECONDARY_EXT_SOURCE_BIT[2],
		gst_pkg::MAIN_EXT_SOURCE_BIT[1]});
	assign gate_comb = ((or_sel & next_src) != 2'h0) ||
		((and_sel != 2'h0) && ((and_sel & next_src) == and_sel));
	assign gate_rise = gate_comb && !o_gate;

	// Source gate state, cleared whenever acquisition stops
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n || !run) begin
			main_gate  <= 1'b0;
			main_armed <= 1'b0;
			sec_gate   <= 1'b0;
			o_gate     <= 1'b0;
		end else begin
			main_gate  <= next_main_gate;
			main_armed <= next_main_armed;
			sec_gate   <= next_sec_gate;
			o_gate     <= gate_comb;
		end
	end

	// Sample index of the current sample
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n || !run) begin
			sample_cnt <= gst_pkg::RST_ZERO;
		end else if (i_sample_valid) begin
			sample_cnt <= sample_cnt + 32'h1;
		end
	end

	// Pad so that gate length lands on the boundary; align is a power of two
	assign next_pad = (ts_start - sample_cnt) & (align - 32'h1);
	assign mem_last = (mem_left <= 32'h1);

	// Segment sequencer: gate, pad, posttrigger, descriptor
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			state        <= gst_pkg::S_IDLE;
			ts_start     <= gst_pkg::RST_ZERO;
			ts_end       <= gst_pkg::RST_ZERO;
			pad_q        <= gst_pkg::RST_ZERO;
			cnt          <= gst_pkg::RST_ZERO;
			mem_left     <= gst_pkg::RST_ZERO;
			o_ts_strobe  <= 1'b0;
			o_ts_is_end  <= 1'b0;
			o_ts_value   <= gst_pkg::RST_ZERO;
			o_seg_strobe <= 1'b0;
			o_seg_first  <= gst_pkg::RST_ZERO;
			o_seg_len    <= gst_pkg::RST_ZERO;
		end else begin
			o_ts_strobe  <= 1'b0;
			o_seg_strobe <= 1'b0;
			if (!run) begin
				state <= gst_pkg::S_IDLE;
			end else begin
				case (state)
					gst_pkg::S_IDLE: begin
						state    <= gst_pkg::S_WAIT;
						mem_left <= memsize;
					end
					gst_pkg::S_WAIT: begin
						if (sv && gate_rise) begin
							ts_start    <= sample_cnt;
							o_ts_value  <= sample_cnt;
							o_ts_strobe <= ts_en;
							o_ts_is_end <= 1'b0;
							mem_left    <= mem_left - pre - 32'h1;
							state       <= gst_pkg::S_GATE;
						end
					end
					gst_pkg::S_GATE: begin
						if (sv && mem_last) begin
							// Memory full with gate still open: extra closing stamp
							ts_end       <= sample_cnt;
							o_ts_value   <= sample_cnt;
							o_ts_strobe  <= ts_en;
							o_ts_is_end  <= 1'b1;
							o_seg_strobe <= 1'b1;
							o_seg_first  <= ts_start - pre;
							o_seg_len    <= sample_cnt - ts_start + pre;
							state        <= gst_pkg::S_DONE;
						end else if (sv) begin
							mem_left <= mem_left - 32'h1;
							if (!gate_comb) begin
								ts_end      <= sample_cnt;
								o_ts_value  <= sample_cnt;
								o_ts_strobe <= ts_en;
								o_ts_is_end <= 1'b1;
								pad_q       <= next_pad;
								cnt         <= (next_pad == 32'h0) ? post : next_pad;
								state       <= (next_pad == 32'h0) ? gst_pkg::S_POST :
									gst_pkg::S_ALIGN;
							end
						end
					end
					gst_pkg::S_ALIGN: begin
						if (sv && mem_last) begin
							state <= gst_pkg::S_DONE;
						end else if (sv) begin
							mem_left <= mem_left - 32'h1;
							cnt      <= (cnt == 32'h1) ? post : cnt - 32'h1;
							if (cnt == 32'h1) begin
								state <= gst_pkg::S_POST;
							end
						end
					end
					gst_pkg::S_POST: begin
						if (cnt == 32'h0) begin
							o_seg_strobe <= 1'b1;
							o_seg_first  <= ts_start - pre;
							o_seg_len    <= ts_end - ts_start + pad_q + pre + post;
							state        <= gst_pkg::S_WAIT;
						end else if (sv && mem_last) begin
							state <= gst_pkg::S_DONE;
						end else if (sv) begin
							mem_left <= mem_left - 32'h1;
							cnt      <= cnt - 32'h1;
						end
					end
					gst_pkg::S_DONE: begin
						state <= gst_pkg::S_DONE;
					end
					default: begin
						state <= gst_pkg::S_IDLE;
					end
				endcase
			end
		end
	end

	// Status outputs, one cycle behind the sequencer
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_record <= 1'b0;
			o_done   <= 1'b0;
		end else begin
			o_record <= (state == gst_pkg::S_GATE) || (state == gst_pkg::S_ALIGN) ||
				(state == gst_pkg::S_POST);
			o_done   <= (state == gst_pkg::S_DONE);
		end
	end

	property p_no_mask_no_gate;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(or_sel == 2'h0 && and_sel == 2'h0) |=> (!o_gate || $past(or_mask) != or_mask
			|| $past(and_mask) != and_mask);
	endproperty
	a_no_mask_no_gate: assert property (p_no_mask_no_gate) else $error("gate with empty masks");

	property p_main_or_bit;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(run && or_sel[0] && next_main_gate) |=> o_gate;
	endproperty
	a_main_or_bit: assert property (p_main_or_bit) else $error("main source not ORed in");

	property p_sec_no_rearm;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		sec_rearm |=> !sec_gate;
	endproperty
	a_sec_no_rearm: assert property (p_sec_no_rearm) else $error("secondary ran re-arm");

	property p_rise_open;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(run && main_pos && !main_rearm && up_a) |=> main_gate;
	endproperty
	a_rise_open: assert property (p_rise_open) else $error("rising edge did not open");

	property p_no_first_sample;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(run && !have_prev) |=> !main_gate && !sec_gate;
	endproperty
	a_no_first_sample: assert property (p_no_first_sample) else $error("opened at start");

	property p_fall_open;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(run && main_neg && !main_rearm && down_a) |=> main_gate;
	endproperty
	a_fall_open: assert property (p_fall_open) else $error("falling edge did not open");

	property p_disarmed_blocks;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(run && main_rearm && main_pos && !main_armed && !main_gate) |=> !main_gate;
	endproperty
	a_disarmed_blocks: assert property (p_disarmed_blocks) else $error("opened disarmed");

	property p_rearm_close;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(run && main_rearm && main_pos && down_a) |=> !main_gate;
	endproperty
	a_rearm_close: assert property (p_rearm_close) else $error("re-arm gate not closed");

	property p_post_aligned;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(state == gst_pkg::S_GATE) ##1 (state == gst_pkg::S_POST || state == gst_pkg::S_ALIGN)
			|-> ((ts_end - ts_start + pad_q) & (align - 32'h1)) == 32'h0;
	endproperty
	a_post_aligned: assert property (p_post_aligned) else $error("gate end not aligned");

	property p_start_stamp;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(state == gst_pkg::S_WAIT && run && sv && gate_rise && ts_en)
			|=> o_ts_strobe && !o_ts_is_end && o_ts_value == $past(sample_cnt);
	endproperty
	a_start_stamp: assert property (p_start_stamp) else $error("missing start stamp");

	property p_seg_span;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(o_seg_strobe && state == gst_pkg::S_WAIT)
			|-> o_seg_first + o_seg_len == ts_end + pad_q + post;
	endproperty
	a_seg_span: assert property (p_seg_span) else $error("segment span wrong");

	property p_mem_expire;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(run && state == gst_pkg::S_GATE && sv && mem_last)
			|=> state == gst_pkg::S_DONE && o_seg_strobe && o_ts_is_end ##1 o_done;
	endproperty
	a_mem_expire: assert property (p_mem_expire) else $error("memsize expiry not handled");
endmodule // gst_gate_trigger
`default_nettype wire

// ---- sim/gst_sig_src.sv ----
`timescale 1ns/1ps
`default_nettype none
// Trigger signal source: one sample per push request
module gst_sig_src (
	input  wire logic        i_clk_sys,
	input  wire logic        i_push,
	input  wire logic [15:0] i_main,
	input  wire logic [15:0] i_sec,
	output logic             o_valid,
	output logic      [15:0] o_main,
	output logic      [15:0] o_sec
);
	// Idle lines flip each cycle so a stale value never passes for a sample
	always_ff @(posedge i_clk_sys) begin
		o_valid <= i_push;
		o_main  <= i_push ? i_main : ~o_main;
		o_sec   <= i_push ? i_sec : ~o_sec;
	end
endmodule // gst_sig_src
`default_nettype wire

// ---- sim/gated_sampling_ext_trigger_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module gated_sampling_ext_trigger_tb_top;
	logic        i_clk_sys = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, push = 0;
	logic        o_pready, o_pslverr, i_sample_valid, o_gate, o_record, o_done, rdy, err, g;
	logic        o_ts_strobe, o_ts_is_end, o_seg_strobe;
	logic [17:0] i_paddr = 0;
	logic [15:0] ma = 0, se = 0, i_main_ext_sample, i_sec_ext_sample;
	logic [31:0] i_pwdata = 0, o_prdata, o_ts_value, o_seg_first, o_seg_len, rd, sf, sl;
	logic [7:0]  sn = 0, sn0;
	int          miscompares = 0, checks_done = 0, seed = 26826, lvl, k;
	// System clock
	always #5 i_clk_sys = ~i_clk_sys;
	gst_sig_src gst_sig_src_i (.i_clk_sys, .i_push(push), .i_main(ma), .i_sec(se),
		.o_valid(i_sample_valid), .o_main(i_main_ext_sample), .o_sec(i_sec_ext_sample));
	gst_gate_trigger gst_gate_trigger_i (.i_clk_sys, .i_rst_n, .i_psel, .i_penable, .i_pwrite,
		.i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_sample_valid,
		.i_main_ext_sample, .i_sec_ext_sample, .o_gate, .o_record, .o_done, .o_ts_strobe,
		.o_ts_is_end, .o_ts_value, .o_seg_strobe, .o_seg_first, .o_seg_len);
	// Descriptor pulses last one cycle, so catch them at every edge
	always @(posedge i_clk_sys) begin
		if (o_seg_strobe === 1) begin
			{sn, sf, sl} <= {sn + 8'd1, o_seg_first, o_seg_len};
		end
	end
	task automatic stop_test;
		$display("checks=%0d mismatches=%0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic cmp(input logic [71:0] got, input logic [71:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// APB transfer; the answer is taken at the rising edge that completes it
	task automatic apb(input logic w, input logic [15:0] ix, input logic [31:0] d);
		@(posedge i_clk_sys);
		{i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, ix, 2'b00, d};
		@(posedge i_clk_sys);
		i_penable <= 1;
		do begin
			@(posedge i_clk_sys);
			{rdy, err, rd} = {o_pready, o_pslverr, o_prdata};
		end while (rdy !== 1);
		{i_psel, i_penable} <= 2'b00;
	endtask
	// One sample; returns once the deciding edge's results have landed
	task automatic smp(input logic [15:0] a, input logic [15:0] b);
		@(posedge i_clk_sys);
		{push, ma, se} <= {1'b1, a, b};
		@(posedge i_clk_sys);
		push <= 0;
		@(posedge i_clk_sys);
		#1;
	endtask
	function automatic logic nxt(input logic gi, input logic fall, input int p, input int c);
		logic up, dn;
		up = p < lvl && c >= lvl;
		dn = p > lvl && c <= lvl;
		return fall ? (dn | (gi & ~up)) : (up | (gi & ~dn));
	endfunction
	task automatic setup(input logic [31:0] orm, input logic [31:0] andm, input logic [31:0] md);
		apb(1, gst_pkg::IDX_CTRL, 0);
		apb(1, gst_pkg::IDX_OR_MASK, orm);
		apb(1, gst_pkg::IDX_AND_MASK, andm);
		apb(1, gst_pkg::IDX_MODE_MAIN, md);
		apb(1, gst_pkg::IDX_MODE_SEC, md);
	endtask
	// Random samples on both inputs; only the enabled one may steer the gate
	task automatic edge_run(input logic [31:0] orm, input logic [31:0] andm, input logic fall,
		input logic sel);
		int p, c, o;
		setup(orm, andm, fall ? gst_pkg::FALLING_EDGE_MODE : gst_pkg::RISING_EDGE_MODE);
		lvl = $random(seed) % 100;
		apb(1, gst_pkg::IDX_LVL_FIRST, 32'(lvl));
		apb(1, gst_pkg::IDX_SEC_LVL, 32'(lvl));
		apb(1, gst_pkg::IDX_CTRL, 1);
		g = 0;
		p = fall ? lvl - 50 : lvl + 50;
		repeat (2) smp(16'(p), 16'(p));
		cmp(o_gate, 0);
		repeat (24) begin
			c = lvl + $random(seed) % 4 * 10;
			o = lvl + $random(seed) % 4 * 10;
			smp(16'(sel ? o : c), 16'(sel ? c : o));
			g = nxt(g, fall, p, c);
			p = c;
			cmp(o_gate, g);
		end
	endtask
	initial begin
		int t [8] = '{-200, -50, 200, 50, 200, -200, -50, 200};
		bit e [8] = '{0, 0, 1, 0, 0, 0, 0, 1};
		repeat (2) @(posedge i_clk_sys);
		i_rst_n <= 1;
		apb(0, gst_pkg::IDX_ALIGN, 0);
		cmp(rd, gst_pkg::RST_ALIGN);
		apb(0, 16'h0000, 0);
		cmp({err, rd}, {1'b1, 32'h0});
		edge_run(gst_pkg::MAIN_EXT_SOURCE_BIT, 0, 0, 0);
		edge_run(gst_pkg::SECONDARY_EXT_SOURCE_BIT, 0, 1, 1);
		edge_run(0, gst_pkg::SECONDARY_EXT_SOURCE_BIT, 0, 1);
		edge_run(0, gst_pkg::MAIN_EXT_SOURCE_BIT, 1, 0);
		// Gate of random length with pad, pre and post
		setup(gst_pkg::MAIN_EXT_SOURCE_BIT, 0, gst_pkg::RISING_EDGE_MODE);
		apb(1, gst_pkg::IDX_LVL_FIRST, 0);
		apb(1, gst_pkg::IDX_ALIGN, 4);
		apb(1, gst_pkg::IDX_PRE, 2);
		apb(1, gst_pkg::IDX_POST, 3);
		apb(1, gst_pkg::IDX_CTRL, 3);
		sn0 = sn;
		k = $unsigned($random(seed)) % 8 + 1;
		repeat (3) smp(-16'sd100, 0);
		smp(16'd100, 0);
		cmp({o_ts_strobe, o_ts_is_end, o_ts_value}, {2'b10, 32'd3});
		repeat (k) smp(16'd100, 0);
		smp(-16'sd100, 0);
		cmp({o_ts_strobe, o_ts_is_end, o_ts_value}, {2'b11, 32'(4 + k)});
		repeat (12) smp(-16'sd100, 0);
		cmp({sn - sn0, sf, sl}, {8'd1, 32'd1, 32'(k + 6 + ((-1 - k) & 3))});
		// Re-arm on main, rising then mirrored falling; secondary must stay closed
		for (int n = 0; n < 2; n++) begin
			setup(32'h6, 0, gst_pkg::REARM_QUALIFIER |
				(n ? gst_pkg::FALLING_EDGE_MODE : gst_pkg::RISING_EDGE_MODE));
			apb(1, gst_pkg::IDX_LVL_FIRST, 100);
			apb(1, gst_pkg::IDX_LVL_SECOND, -32'sd100);
			apb(1, gst_pkg::IDX_CTRL, 1);
			foreach (t[i]) begin
				smp(16'(n ? -t[i] : t[i]), 16'(n ? -t[i] : t[i]));
				cmp(o_gate, e[i]);
			end
		end
		// Memory runs out with the gate open: start at sample 1, full at sample 6
		setup(gst_pkg::MAIN_EXT_SOURCE_BIT, 0, gst_pkg::RISING_EDGE_MODE);
		apb(1, gst_pkg::IDX_LVL_FIRST, 0);
		apb(1, gst_pkg::IDX_MEMSIZE, 8);
		apb(1, gst_pkg::IDX_CTRL, 3);
		sn0 = sn;
		smp(-16'sd100, 0);
		repeat (2) smp(16'd100, 0);
		cmp({o_done, o_record}, 2'b01);
		repeat (4) smp(16'd100, 0);
		cmp({o_ts_strobe, o_ts_is_end, o_ts_value}, {2'b11, 32'd6});
		smp(16'd100, 0);
		cmp({o_done, o_record}, 2'b10);
		cmp({sn - sn0, sf, sl}, {8'd1, 32'(1 - 2), 32'(6 - 1 + 2)});
		apb(0, gst_pkg::IDX_TS_START, 0);
		cmp(rd, 32'd1);
		apb(0, gst_pkg::IDX_STATUS, 0);
		cmp(rd, 32'h0000_003b);
		stop_test;
	end
	// Watchdog well beyond the expected run length
	initial begin
		#200000;
		miscompares++;
		stop_test;
	end
endmodule // gated_sampling_ext_trigger_tb_top
`default_nettype wire
